// file: inc/shbp_defines.svh
/*
  Constants of the synchronous host bus port: field widths, slave register
  indices, upper-lane fill value, buffer depth and reset values.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef SHBP_DEFINES_SVH
`define SHBP_DEFINES_SVH

`define SHBP_ADDR_W 24
`define SHBP_DATA_W 16
`define SHBP_REG_SEL_W 3
`define SHBP_REG_STATUS 3'h0
`define SHBP_REG_CMD 3'h2
`define SHBP_REG_DATA_LO 3'h4
`define SHBP_REG_DATA_HI 3'h6
`define SHBP_VECTOR_RST 8'h0F
`define SHBP_STATUS_RST 8'hFF
`define SHBP_UPPER_FILL 8'hFF
`define SHBP_BUF_DEPTH 2

`endif

// file: inc/shbp_pkg.sv
/*
  Types of the synchronous host bus port: controller state and DMA request.
  Assumes shbp_defines.svh sits on the include path.
*/
`include "shbp_defines.svh"

package shbp_pkg;

  // One-hot master states
  typedef enum logic [6:0] {
    SHBP_IDLE = 7'b000_0001,
    SHBP_REQ = 7'b000_0010,
    SHBP_ADDR = 7'b000_0100,
    SHBP_WAIT = 7'b000_1000,
    SHBP_RELEASE = 7'b001_0000,
    SHBP_PARK = 7'b010_0000,
    SHBP_FAULT = 7'b100_0000
  } shbp_state_t;

  // One DMA request from the block's core
  typedef struct packed {
    logic write;
    logic [`SHBP_ADDR_W-1:0] addr;
    logic [`SHBP_DATA_W-1:0] data;
  } shbp_dma_t;

endpackage : shbp_pkg

// file: rtl/shbp_host_port.sv
/*
  Synchronous-style host bus port: slave register access, vector fetch,
  hold arbitration and DMA master cycles with ready, halt, retry, fault.
  Assumes all bus pins come from another clock domain; two-way pins are
  split into input, output and enable; the testbench resolves the wires.
*/
// Function
// - Style select high disables this bus style
// - Chip select or acknowledge enters slave mode
// - Master mode runs DMA reads and writes
// - Two-way pins direction follows master/slave mode
// - 24-bit address; A1,A2 select registers as slave
// - Address line 0 low enables low lane
// - Eight or sixteen bit data bus
// - Register chosen by A0-A2 and upper enable
// - Address strobe low marks valid address
// - Read strobe low: master reads, slave drives
// - Write strobe low: master writes, slave latches
// - Upper enable and A0 pick byte lanes
// - 8-bit bus uses low lanes; idle strobes
// - Wait states until ready, then end cycle
// - Slave drives ready before completion edge
// - Hold request stays while owning bus
// - Lost grant: finish on ready, release, drop request
// - Service request raised when service needed
// - Acknowledge drives vector, drops service request
// - Vector driven on acknowledge reads only; the port answers an acknowledge read only while it holds no bus request
// - Fault aborts, releases, rearbitrates, reports
// - Retry ends cycle, reruns after exceptions clear
// - Halt stops after ready, resumes later

// Constants are taken from the shared header; its guard makes a second include harmless
`include "shbp_defines.svh"

module shbp_host_port (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_bus_style_select,
  input wire logic i_bus_width_16,
  input wire logic i_cs_n,
  input wire logic i_service_ack_in_n,
  input wire logic [2:0] i_addr_lo,
  input wire logic i_upper_byte_enable_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [`SHBP_DATA_W-1:0] i_data,
  input wire logic i_ready,
  input wire logic i_bus_hold_grant,
  input wire logic i_halt_n,
  input wire logic i_bus_fault_in_n,
  input wire logic i_retry_n,
  input wire logic i_irq_event,
  input wire logic [7:0] i_vector,
  input wire logic i_dma_valid,
  output logic o_dma_ready,
  input wire shbp_pkg::shbp_dma_t i_dma_req,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [`SHBP_DATA_W-1:0] o_rd_data,
  output logic [7:0] o_cmd,
  output logic o_cmd_strobe,
  output logic o_fault_report,
  output logic [`SHBP_ADDR_W-1:0] o_addr,
  output logic o_addr_oe,
  output logic [`SHBP_DATA_W-1:0] o_data,
  output logic [1:0] o_data_oe,
  output logic o_address_valid_strobe_n,
  output logic o_upper_byte_enable_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_ctl_oe,
  output logic o_ready,
  output logic o_ready_oe,
  output logic o_bus_hold_request,
  output logic o_service_request_out
);
  import shbp_pkg::*;

  localparam int SYNC_W = 13 + `SHBP_DATA_W;

  // Whole state in one record
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic slv_act;
    logic [7:0] status;
    logic [7:0] cmd;
    logic cmd_strobe;
    logic [`SHBP_DATA_W-1:0] dr;
    shbp_state_t state;
    shbp_dma_t cur;
    logic cur_ok;
    logic rerun;
    logic fault;
    logic irq;
    logic [1:0] wp;
    logic [1:0] rp;
    shbp_dma_t [`SHBP_BUF_DEPTH-1:0] buf_mem;
    logic [`SHBP_DATA_W-1:0] rd_data;
    logic rd_valid;
    logic [`SHBP_ADDR_W-1:0] addr;
    logic addr_oe;
    logic [`SHBP_DATA_W-1:0] dout;
    logic [1:0] doe;
    logic as_n;
    logic ube_n;
    logic rd_n;
    logic wr_n;
    logic ctl_oe;
    logic ready;
    logic ready_oe;
    logic bus_hold_request;
    logic dma_rdy;
  } shbp_regs_t;

  shbp_regs_t r;
  shbp_regs_t next_r;

  // Synchronised pin copies, taken from the second stage only
  logic cs_n, ack_n, ube_in_n, rd_in_n, wr_in_n, rdy, grant, halt_n, fault_n, retry_n;
  logic [2:0] a_lo;
  logic [`SHBP_DATA_W-1:0] din;
  logic sync_mode, exc, slave_hit, buf_full, buf_empty, lo_en, hi_en;
  shbp_dma_t head;

  assign {cs_n, ack_n, a_lo, ube_in_n, rd_in_n, wr_in_n, rdy, grant, halt_n, fault_n, retry_n, din} = r.s2;
  assign sync_mode = ~i_bus_style_select;
  assign exc = ~halt_n | ~fault_n | ~retry_n;
  assign buf_full = (r.wp[0] == r.rp[0]) && (r.wp[1] != r.rp[1]);
  assign buf_empty = (r.wp == r.rp);
  assign head = r.buf_mem[r.rp[0]];
  // Lane decode for slave cycles; 8-bit bus always uses the low lane
  assign lo_en = i_bus_width_16 ? ~a_lo[0] : 1'b1;
  assign hi_en = i_bus_width_16 & ~ube_in_n;
  assign slave_hit = sync_mode && (~cs_n || ~ack_n) && (rd_in_n ^ wr_in_n);

  always_comb begin
    next_r = r;
    // Two flip-flops ahead of all bus pin logic; style select, bus width and vector are used directly
    next_r.s1 = {i_cs_n, i_service_ack_in_n, i_addr_lo, i_upper_byte_enable_n, i_rd_n, i_wr_n,
                 i_ready, i_bus_hold_grant, i_halt_n, i_bus_fault_in_n, i_retry_n, i_data};
    next_r.s2 = r.s1;
    next_r.cmd_strobe = 1'b0;
    next_r.fault = 1'b0;

    // Buffer fill side; drain side below may free a slot in the same cycle
    if (i_dma_valid && !buf_full) begin
      next_r.buf_mem[r.wp[0]] = i_dma_req;
      next_r.wp = r.wp + 2'd1;
    end
    if (r.rd_valid && i_rd_ready) begin
      next_r.rd_valid = 1'b0;
    end

    // Service request: new event wins over a same-cycle acknowledge
    if (i_irq_event) begin
      next_r.irq = 1'b1;
    end else if (sync_mode && ~ack_n && r.state == SHBP_IDLE) begin
      next_r.irq = 1'b0;
    end

    // Slave side: only when not owning the bus
    next_r.slv_act = slave_hit && !r.bus_hold_request;
    if (slave_hit && !r.bus_hold_request) begin
      next_r.ready_oe = 1'b1;
      next_r.ready = 1'b1;
      if (!rd_in_n) begin
        // Host read: vector on acknowledge, else selected register
        next_r.doe = {hi_en, lo_en};
        if (~ack_n) begin
          next_r.dout = {`SHBP_UPPER_FILL, i_vector};
        end else begin
          unique case ({a_lo[2:1], 1'b0})
            `SHBP_REG_DATA_LO: next_r.dout = {`SHBP_UPPER_FILL, r.dr[7:0]};
            `SHBP_REG_DATA_HI: next_r.dout = {`SHBP_UPPER_FILL, r.dr[15:8]};
            default: next_r.dout = {`SHBP_UPPER_FILL, r.status};
          endcase
          if (hi_en && !lo_en) begin
            next_r.dout = {r.status, `SHBP_UPPER_FILL}; // Upper lane only
          end
        end
      end else if (!r.slv_act && ~cs_n) begin
        // Host write latched once at cycle start
        next_r.doe = 2'b00;
        unique case ({a_lo[2:1], 1'b0})
          `SHBP_REG_CMD: begin
            next_r.cmd = (hi_en && !lo_en) ? din[15:8] : din[7:0];
            next_r.cmd_strobe = 1'b1;
          end
          `SHBP_REG_DATA_LO: begin
            if (lo_en) next_r.dr[7:0] = din[7:0];
            if (hi_en) next_r.dr[15:8] = din[15:8];
          end
          `SHBP_REG_DATA_HI: next_r.dr[15:8] = i_bus_width_16 ? din[15:8] : din[7:0];
          default: next_r.status = r.status;
        endcase
      end
    end else if (!r.bus_hold_request) begin
      next_r.doe = 2'b00;
      next_r.ready = 1'b0;
      next_r.ready_oe = 1'b0;
    end

    // Master sequence
    unique case (r.state)
      SHBP_IDLE: begin
        next_r.ctl_oe = 1'b0;
        next_r.addr_oe = 1'b0;
        if (sync_mode && !exc && (r.cur_ok || !buf_empty) && !r.slv_act && !slave_hit) begin
          next_r.bus_hold_request = 1'b1;
          next_r.state = SHBP_REQ;
        end
      end
      SHBP_REQ: begin
        if (exc) begin
          next_r.state = SHBP_RELEASE;
        end else if (grant) begin
          if (!r.cur_ok) begin
            next_r.cur = head;
            next_r.cur_ok = 1'b1;
            next_r.rp = r.rp + 2'd1;
          end
          next_r.state = SHBP_ADDR;
        end
      end
      SHBP_ADDR: begin
        // Drive address as bus owner; strobes only once the last ready has gone
        next_r.ready_oe = 1'b0;
        next_r.ctl_oe = 1'b1;
        next_r.addr_oe = 1'b1;
        next_r.addr = r.cur.addr;
        // A ready still seen from the previous cycle would end this one at once,
        // and its synchronised data would belong to the old address
        if (!rdy) begin
          next_r.as_n = 1'b0;
          next_r.rd_n = r.cur.write;
          next_r.wr_n = ~r.cur.write;
          next_r.ube_n = ~i_bus_width_16;
          next_r.dout = r.cur.data;
          next_r.doe = r.cur.write ? {i_bus_width_16, 1'b1} : 2'b00;
          next_r.state = SHBP_WAIT;
        end
      end
      SHBP_WAIT: begin
        if (!fault_n) begin
          next_r.cur_ok = 1'b0;
          next_r.fault = 1'b1;
          next_r.state = SHBP_FAULT;
        end else if (!retry_n) begin
          next_r.state = SHBP_PARK;
        end else if (rdy && (r.cur.write || !r.rd_valid)) begin
          // Completed cycle; read data waits in the output slot
          next_r.cur_ok = 1'b0;
          if (!r.cur.write) begin
            next_r.rd_data = i_bus_width_16 ? din : {8'h00, din[7:0]};
            next_r.rd_valid = 1'b1;
          end
          if (!halt_n || !grant || buf_empty) begin
            next_r.state = SHBP_RELEASE;
          end else begin
            // Back-to-back: strobes go inactive between cycles so the slave sees an end
            next_r.as_n = 1'b1;
            next_r.rd_n = 1'b1;
            next_r.wr_n = 1'b1;
            next_r.doe = 2'b00;
            next_r.cur = head;
            next_r.cur_ok = 1'b1;
            next_r.rp = r.rp + 2'd1;
            next_r.state = SHBP_ADDR;
          end
        end
      end
      SHBP_FAULT, SHBP_PARK, SHBP_RELEASE: begin
        // Float the bus first, then drop the request a cycle later
        next_r.as_n = 1'b1;
        next_r.rd_n = 1'b1;
        next_r.wr_n = 1'b1;
        next_r.ube_n = 1'b1;
        next_r.doe = 2'b00;
        if (!r.ctl_oe) begin
          next_r.bus_hold_request = 1'b0;
          if (!exc) begin
            next_r.state = SHBP_IDLE;
          end
        end
        next_r.ctl_oe = 1'b0;
        next_r.addr_oe = 1'b0;
      end
      default: next_r.state = SHBP_IDLE;
    endcase

    // Buffer space flag registered from the next pointers, so it matches them exactly
    next_r.dma_rdy = !((next_r.wp[0] == next_r.rp[0]) && (next_r.wp[1] != next_r.rp[1]));

    if (i_srst) begin
      next_r = '0;
      next_r.dma_rdy = 1'b1;
      next_r.state = SHBP_IDLE;
      next_r.s1 = '1;
      next_r.s2 = '1;
      next_r.status = `SHBP_STATUS_RST;
      next_r.as_n = 1'b1;
      next_r.ube_n = 1'b1;
      next_r.rd_n = 1'b1;
      next_r.wr_n = 1'b1;
    end
  end

  // Single register stage for all state
  always_ff @(posedge i_mclk) begin
    r <= next_r;
  end

  // Outputs straight from flip-flops
  assign o_dma_ready = r.dma_rdy;
  assign o_rd_valid = r.rd_valid;
  assign o_rd_data = r.rd_data;
  assign o_cmd = r.cmd;
  assign o_cmd_strobe = r.cmd_strobe;
  assign o_fault_report = r.fault;
  assign o_addr = r.addr;
  assign o_addr_oe = r.addr_oe;
  assign o_data = r.dout;
  assign o_data_oe = r.doe;
  assign o_address_valid_strobe_n = r.as_n;
  assign o_upper_byte_enable_n = r.ube_n;
  assign o_rd_n = r.rd_n;
  assign o_wr_n = r.wr_n;
  assign o_ctl_oe = r.ctl_oe;
  assign o_ready = r.ready;
  assign o_ready_oe = r.ready_oe;
  assign o_bus_hold_request = r.bus_hold_request;
  assign o_service_request_out = r.irq;

endmodule : shbp_host_port

// file: dv/shbp_props.sv
/*
  Checker of the host bus port pins and flags.
  Assumes a bind onto shbp_host_port; a single clock.
*/
module shbp_props (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_bus_style_select,
  input wire logic i_irq_event,
  input wire logic o_fault_report,
  input wire logic o_rd_valid,
  input wire logic o_rd_n,
  input wire logic o_wr_n,
  input wire logic o_address_valid_strobe_n,
  input wire logic o_ctl_oe,
  input wire logic o_addr_oe,
  input wire logic o_ready_oe,
  input wire logic [1:0] o_data_oe,
  input wire logic o_bus_hold_request,
  input wire logic o_service_request_out
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // Bus fully let go: no strobes, no address
  sequence s_released;
    !o_ctl_oe && !o_addr_oe;
  endsequence
  // Reset check must run while reset is high, so it is never disabled
  a_reset_quiet:
    assert property (disable iff (1'b0) i_srst |=> !o_bus_hold_request && !o_service_request_out
      && !o_ctl_oe && !o_ready_oe && o_data_oe == 2'b00) else $error("outputs active in reset");
  a_irq_raise:
    assert property (i_irq_event && !i_bus_style_select |=> o_service_request_out) else $error("no request");
  a_owner_holds:
    assert property (o_ctl_oe |-> o_bus_hold_request) else $error("strobes without hold");
  a_addr_valid:
    assert property (o_ctl_oe && !o_address_valid_strobe_n |-> o_addr_oe) else $error("strobe no address");
  a_one_strobe:
    assert property (o_ctl_oe |-> o_rd_n || o_wr_n) else $error("both strobes low");
  a_pin_direction:
    assert property (o_ready_oe |-> !o_ctl_oe && !o_addr_oe) else $error("slave and master at once");
  a_fault_release:
    assert property (o_fault_report |-> ##[0:3] s_released) else $error("bus kept after fault");
  a_release_order:
    assert property ($fell(o_bus_hold_request) |-> s_released ##0 !$past(o_ctl_oe)) else $error("early drop");
  a_read_result:
    assert property ($rose(o_rd_valid) |-> !$past(o_rd_n) || !$past(o_rd_n, 2)) else $error("result no read");
endmodule : shbp_props

// file: dv/shbp_mem_model.sv
/*
  Arbiter and memory on the far side of the master bus.
  Assumes the bench tells it when a strobe is active.
*/
module shbp_mem_model (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_stall,
  input wire logic [3:0] i_waits,
  input wire logic i_hrq,
  input wire logic i_act,
  input wire logic i_rd,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_data,
  output logic o_grant,
  output logic o_rdy,
  output logic [15:0] o_q,
  output logic [15:0] o_wdata,
  output logic [7:0] o_nwr
);
  logic [3:0] cnt;
  // Read data follows the address so the bench can predict it
  assign o_q = i_addr[15:0] ^ 16'h3C3C;
  // Grant tracks request unless stalled; ready after a set wait, held until strobes go
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_grant <= 1'b0;
      o_rdy <= 1'b0;
      cnt <= 4'h0;
      o_nwr <= 8'h00;
    end else begin
      o_grant <= i_hrq && !i_stall;
      cnt <= !i_act ? 4'h0 : (cnt == i_waits ? cnt : cnt + 4'h1);
      o_rdy <= i_act && cnt == i_waits;
      if (i_act && cnt == i_waits && !o_rdy && !i_rd) begin
        o_nwr <= o_nwr + 8'h01;
        o_wdata <= i_data;
      end
    end
  end
endmodule : shbp_mem_model

// file: dv/shbp_host_port_bench.sv
/*
  Self-checking bench of the host bus port: slave, vector, DMA, fault.
  Assumes straps start at this bus style and a 16-bit bus; t_modes changes both.
*/
module shbp_host_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  wire o_dma_ready, o_rd_valid, o_cmd_strobe, o_fault_report, o_addr_oe, o_address_valid_strobe_n;
  wire o_upper_byte_enable_n, o_rd_n, o_wr_n, o_ctl_oe, o_ready, o_ready_oe, o_bus_hold_request;
  wire o_service_request_out, i_bus_hold_grant, m_rdy;
  wire [15:0] o_rd_data, o_data, m_q, m_wd;
  wire [7:0] o_cmd, m_nwr;
  wire [23:0] o_addr;
  wire [1:0] o_data_oe;
  logic i_mclk = 0, i_srst = 1, i_bus_style_select = 0, i_bus_width_16 = 1, i_cs_n = 1, i_halt_n = 1;
  logic i_service_ack_in_n = 1, i_retry_n = 1, i_bus_fault_in_n = 1, i_irq_event = 0, i_dma_valid = 0;
  logic i_rd_ready = 0, h_rd_n = 1, h_wr_n = 1, ube_n = 1, stall = 0;
  logic [7:0] i_vector = 8'hC3;
  logic [2:0] a = 3'h0;
  logic [15:0] hd = 16'hFFFF;
  logic [3:0] waits = 4'h2;
  shbp_pkg::shbp_dma_t i_dma_req = '0;
  int bad_count = 0, checks = 0, n, nrep = 0, ncmd = 0;
  // Wire levels from every party's enable
  wire act = o_ctl_oe && !o_address_valid_strobe_n && !(o_rd_n && o_wr_n);
  wire [2:0] i_addr_lo = o_addr_oe ? o_addr[2:0] : a;
  wire i_upper_byte_enable_n = o_ctl_oe ? o_upper_byte_enable_n : ube_n;
  wire i_rd_n = o_ctl_oe ? o_rd_n : h_rd_n;
  wire i_wr_n = o_ctl_oe ? o_wr_n : h_wr_n;
  wire [15:0] i_data = o_data_oe != 2'b00 ? o_data : (act && !o_rd_n) ? m_q : hd;
  wire i_ready = o_ready_oe ? o_ready : m_rdy;
  always #10 i_mclk = ~i_mclk;
  shbp_host_port DUT (.*);
  shbp_mem_model u_mem (.i_mclk(i_mclk), .i_srst(i_srst), .i_stall(stall), .i_waits(waits),
    .i_hrq(o_bus_hold_request), .i_act(act), .i_rd(!o_rd_n), .i_addr(o_addr), .i_data(i_data),
    .o_grant(i_bus_hold_grant), .o_rdy(m_rdy), .o_q(m_q), .o_wdata(m_wd), .o_nwr(m_nwr));
  // Count one-cycle pulses so no test has to catch them on the exact edge
  always @(posedge i_mclk) begin
    if (o_fault_report === 1'b1) nrep++;
    if (o_cmd_strobe === 1'b1) ncmd++;
  end
  task ck(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %0t got %h want %h", $time, g, e);
    end
  endtask : ck
  // Host holds its request until it sees ready
  task hacc(input logic c, k, r, w, u, input logic [2:0] ad, input logic [15:0] d);
    @(negedge i_mclk);
    i_cs_n = c; i_service_ack_in_n = k; h_rd_n = r; h_wr_n = w; ube_n = u; a = ad; hd = d;
    for (n = 0; n < 12 && o_ready !== 1'b1; n++) @(negedge i_mclk);
    ck(o_ready, 1);
  endtask : hacc
  task hrel;
    i_cs_n = 1; i_service_ack_in_n = 1; h_rd_n = 1; h_wr_n = 1; hd = 16'hFFFF;
    repeat (6) @(negedge i_mclk);
  endtask : hrel
  task push(input logic w, input logic [23:0] ad, input logic [15:0] d);
    @(negedge i_mclk);
    i_dma_valid = 1; i_dma_req = '{w, ad, d};
    for (n = 0; n < 100 && o_dma_ready !== 1'b1; n++) @(negedge i_mclk);
    @(negedge i_mclk);
    i_dma_valid = 0;
  endtask : push
  task t_lanes;
    for (int i = 0; i < 4; i++) begin
      hacc(0, 1, 0, 1, i[1], {2'b00, i[0]}, 16'hFFFF);
      ck(o_data_oe, 2'(~i[1:0]));
      ck(o_data | {{8{i[1]}}, {8{i[0]}}}, 16'hFFFF);
      if (i < 3) ck(o_ready_oe, 1);
      hrel;
      ck(o_data_oe, 0);
    end
    $display("lanes done");
  endtask : t_lanes
  task t_cmd;
    hacc(0, 1, 1, 0, 1, 3'b010, 16'h005A);
    hrel;
    ck(o_cmd, 8'h5A);
    ck(ncmd, 1);
    $display("command done");
  endtask : t_cmd
  task t_vec;
    i_irq_event = 1;
    @(negedge i_mclk);
    i_irq_event = 0;
    ck(o_service_request_out, 1);
    repeat (2) begin
      hacc(1, 0, 0, 1, 1, 3'b000, 16'hFFFF);
      ck(o_data[7:0], 8'hC3);
      hrel;
      ck(o_service_request_out, 0);
    end
    $display("vector done");
  endtask : t_vec
  task t_dma;
    stall = 1; waits = 4'h3;
    push(1, 24'h00_0010, 16'hBEEF);
    push(0, 24'h00_0020, 16'h0000);
    ck(o_dma_ready, 0); // buffer full while the bus is withheld
    ck(o_bus_hold_request, 1);
    stall = 0;
    for (n = 0; n < 200 && o_rd_valid !== 1'b1; n++) @(negedge i_mclk);
    ck(o_rd_valid, 1);
    ck(m_wd, 16'hBEEF);
    ck(o_rd_data, 16'h0020 ^ 16'h3C3C);
    i_rd_ready = 1;
    @(negedge i_mclk);
    i_rd_ready = 0;
    for (n = 0; n < 20 && o_bus_hold_request !== 1'b0; n++) @(negedge i_mclk);
    ck({o_bus_hold_request, o_dma_ready}, 1);
    push(1, 24'h00_0050, 16'h7777);
    for (n = 0; n < 40 && o_ctl_oe !== 1'b1; n++) @(negedge i_mclk);
    ck(o_ctl_oe, 1);
    stall = 1;
    for (n = 0; n < 40 && o_bus_hold_request !== 1'b0; n++) @(negedge i_mclk);
    ck({m_wd, o_bus_hold_request}, {16'h7777, 1'b0});
    stall = 0;
    $display("dma done");
  endtask : t_dma
  task t_fault;
    waits = 4'hF;
    push(1, 24'h00_0040, 16'h0F0F);
    for (n = 0; n < 40 && o_ctl_oe !== 1'b1; n++) @(negedge i_mclk);
    ck(o_ctl_oe, 1);
    i_bus_fault_in_n = 0;
    repeat (8) @(negedge i_mclk);
    i_bus_fault_in_n = 1;
    ck({nrep, o_ctl_oe}, 2);
    ck(m_nwr, 2);
    repeat (10) @(negedge i_mclk);
    ck(o_bus_hold_request, 0);
    $display("fault done");
  endtask : t_fault
  // Retry mid-cycle: the same write must be rerun once the exception clears
  task t_retry;
    push(1, 24'h00_0060, 16'h1234);
    for (n = 0; n < 40 && o_ctl_oe !== 1'b1; n++) @(negedge i_mclk);
    ck(o_ctl_oe, 1);
    i_retry_n = 0;
    repeat (8) @(negedge i_mclk);
    ck(o_ctl_oe, 0);
    waits = 4'h2;
    i_retry_n = 1;
    for (n = 0; n < 100 && m_nwr !== 8'h03; n++) @(negedge i_mclk);
    ck(m_nwr, 3);
    ck(m_wd, 16'h1234);
    $display("retry done");
  endtask : t_retry
  // Other bus style ignores the host; 8-bit bus answers on the low lane only
  task t_modes;
    i_bus_style_select = 1;
    @(negedge i_mclk);
    i_cs_n = 0; h_rd_n = 0;
    repeat (6) @(negedge i_mclk);
    ck(o_ready_oe, 0);
    hrel;
    i_bus_style_select = 0;
    i_bus_width_16 = 0;
    hacc(0, 1, 0, 1, 0, 3'b001, 16'hFFFF);
    ck(o_data_oe, 1);
    hrel;
    i_bus_width_16 = 1;
    $display("modes done");
  endtask : t_modes
  task results;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // Main sequence: reset checked while held, then each scenario
  initial begin
    repeat (4) @(negedge i_mclk);
    ck({o_bus_hold_request, o_service_request_out, o_ctl_oe, o_ready_oe, o_data_oe}, 0);
    i_srst = 0;
    repeat (4) @(negedge i_mclk);
    t_lanes; t_cmd; t_vec; t_dma; t_fault; t_retry; t_modes;
    results;
  end
  // Tests need a few hundred cycles; this span of 10000 cycles is far beyond that
  initial begin
    #200us;
    bad_count++;
    $display("Error %0t watchdog", $time);
    results;
  end
endmodule : shbp_host_port_bench
bind shbp_host_port shbp_props u_props (.*);
